// >>> src/iopws_pkg.sv
package iopws_pkg;
  // Port geometry
  localparam int PORT_W     = 8;
  localparam int PORT_N     = 4;
  localparam int PIN_N      = 32;
  // Port indices inside the packed pin vector
  localparam int PA         = 0;
  localparam int PB         = 1;
  localparam int PC         = 2;
  localparam int PD         = 3;
  // Reset values
  localparam logic [31:0] DIR_RST   = 32'h00000000;
  localparam logic [31:0] DATA_RST  = 32'h00000000;
  localparam logic [31:0] PULL_RST  = 32'h00000000;
  localparam logic [31:0] WAKE_RST  = 32'h00000000;
  // Shared bit positions
  localparam int PB_IR      = 7;
  localparam int PB_EXT_INT = 6;
  localparam int PB_RTC_HI  = 5;
  localparam int PB_RTC_LO  = 4;
  localparam int PA_TCLK_A  = 4;
  localparam int CC_LO      = 4;
  localparam int SPI_CS     = 0;
  localparam int SPI_CK     = 1;
  localparam int SPI_TX     = 2;
  localparam int SPI_RX     = 3;
  // Wakeup arm state
  typedef enum logic [1:0] {
    IOPWS_IDLE  = 2'b01,
    IOPWS_ARMED = 2'b10
  } iopws_arm_e;
endpackage

// >>> src/iopws_port.sv
`timescale 1ns/1ps
`default_nettype none
module iopws_port
  import iopws_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // Software side
  input  wire logic [31:0] dir_wdata,
  input  wire logic [3:0]  dir_we,
  input  wire logic [31:0] data_wdata,
  input  wire logic [3:0]  data_we,
  input  wire logic [31:0] pull_low_en,
  input  wire logic [31:0] wake_en,
  input  wire logic        key_wake_on,
  input  wire logic        sleeping,
  output logic [31:0]      pin_rdata,
  output logic [31:0]      port_data_latch,
  output logic [31:0]      port_dir,
  output logic             key_wake,
  output logic             wake_out,
  input  wire logic        irq_wake,
  // Pins
  input  wire logic [31:0] pin_i,
  output logic [31:0]      pin_o,
  output logic [31:0]      pin_oe,
  output logic [31:0]      pin_pd,
  // Shared module enables and signals
  input  wire logic [3:0]  led_en,
  input  wire logic [3:0]  led_brightness_outputs,
  input  wire logic        ir_en,
  input  wire logic        ir_out,
  input  wire logic [1:0]  rtc_en,
  input  wire logic [1:0]  rtc_out,
  input  wire logic [2:0]  cc_a_en,
  input  wire logic [2:0]  cc_a_out,
  input  wire logic [2:0]  cc_b_en,
  input  wire logic [2:0]  cc_b_out,
  input  wire logic        i2s_out_en,
  input  wire logic [2:0]  i2s_out,
  input  wire logic        spi_en,
  input  wire logic        spi_cs_o,
  input  wire logic        spi_cs_oe,
  input  wire logic        spi_ck_o,
  input  wire logic        spi_ck_oe,
  input  wire logic        spi_tx_o,
  input  wire logic        spi_tx_oe,
  output logic [7:0]       adc_in,
  output logic [2:0]       timer_clk_in,
  output logic [1:0]       quad_first_in,
  output logic [1:0]       quad_second_in,
  output logic [2:0]       i2s_in,
  output logic             ext_int_in,
  output logic [1:0]       rtc_in,
  output logic             spi_rx_in,
  output logic             spi_cs_in,
  output logic             spi_ck_in
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [31:0] dir;
    logic [31:0] latch;
    logic [31:0] snap;
    iopws_arm_e  arm;
    logic        wake;
  } iopws_state_s;

  iopws_state_s st;
  iopws_state_s next_st;

  // Byte-lane write select, used for both registers
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  we);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < PORT_N; i++) begin
      if (we[i]) begin
        r[i*PORT_W +: PORT_W] = new_v[i*PORT_W +: PORT_W];
      end
    end
    return r;
  endfunction

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  // Snapshot of the pin levels taken at arming; the latch plays no part
  always_comb begin
    next_st       = st;
    next_st.dir   = lane_merge(st.dir, dir_wdata, dir_we);
    next_st.latch = lane_merge(st.latch, data_wdata, data_we);
    next_st.wake  = 1'b0;
    case (st.arm)
      IOPWS_IDLE: begin
        if (key_wake_on) begin
          next_st.arm  = IOPWS_ARMED;
          next_st.snap = pin_i;
        end
      end
      IOPWS_ARMED: begin
        if (!key_wake_on) begin
          next_st.arm = IOPWS_IDLE;
        end else if (|((pin_i ^ st.snap) & wake_en)) begin
          next_st.wake = 1'b1;
        end
      end
      default: begin
        next_st.arm = IOPWS_IDLE;
      end
    endcase
  end

  // Clock enable freezes all state; reset still acts while ce is low
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st.dir   <= DIR_RST;
      st.latch <= DATA_RST;
      st.snap  <= DATA_RST;
      st.arm   <= IOPWS_IDLE;
      st.wake  <= 1'b0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Pin muxing
  // ----------------------------------------
  // GPIO default, then shared functions override per pin
  always_comb begin
    pin_o  = st.latch;
    pin_oe = st.dir;
    // LED brightness, IR, RTC on port B
    for (int i = 0; i < 4; i++) begin
      if (led_en[i]) begin
        pin_o[PB*PORT_W+i]  = led_brightness_outputs[i];
        pin_oe[PB*PORT_W+i] = 1'b1;
      end
    end
    if (ir_en) begin
      pin_o[PB*PORT_W+PB_IR]  = ir_out;
      pin_oe[PB*PORT_W+PB_IR] = 1'b1;
    end
    for (int i = 0; i < 2; i++) begin
      if (rtc_en[i]) begin
        pin_o[PB*PORT_W+PB_RTC_LO+i]  = rtc_out[i];
        pin_oe[PB*PORT_W+PB_RTC_LO+i] = 1'b1;
      end
    end
    // Capture/compare on A4..A6 and B4..B6
    for (int i = 0; i < 3; i++) begin
      if (cc_a_en[i]) begin
        pin_o[PA*PORT_W+CC_LO+i]  = cc_a_out[i];
        pin_oe[PA*PORT_W+CC_LO+i] = 1'b1;
      end
      if (cc_b_en[i]) begin
        pin_o[PB*PORT_W+CC_LO+i]  = cc_b_out[i];
        pin_oe[PB*PORT_W+CC_LO+i] = 1'b1;
      end
    end
    // Audio out on A5..A7; wins over capture/compare on shared A5/A6
    if (i2s_out_en) begin
      for (int i = 0; i < 3; i++) begin
        pin_o[PA*PORT_W+5+i]  = i2s_out[i];
        pin_oe[PA*PORT_W+5+i] = 1'b1;
      end
    end
    // SPI owns D0..D3 outright; GPIO bits are ignored
    if (spi_en) begin
      pin_o[PD*PORT_W+SPI_CS]  = spi_cs_o;
      pin_oe[PD*PORT_W+SPI_CS] = spi_cs_oe;
      pin_o[PD*PORT_W+SPI_CK]  = spi_ck_o;
      pin_oe[PD*PORT_W+SPI_CK] = spi_ck_oe;
      pin_o[PD*PORT_W+SPI_TX]  = spi_tx_o;
      pin_oe[PD*PORT_W+SPI_TX] = spi_tx_oe;
      pin_o[PD*PORT_W+SPI_RX]  = 1'b0;
      pin_oe[PD*PORT_W+SPI_RX] = 1'b0;
    end
  end

  // Weak pull-low only on pins not being driven
  assign pin_pd = pull_low_en & ~pin_oe;

  // Input taps for shared modules
  assign adc_in         = pin_i[PC*PORT_W +: PORT_W];
  assign spi_cs_in      = pin_i[PD*PORT_W+SPI_CS];
  assign spi_ck_in      = pin_i[PD*PORT_W+SPI_CK];
  assign spi_rx_in      = pin_i[PD*PORT_W+SPI_RX];
  assign ext_int_in     = pin_i[PB*PORT_W+PB_EXT_INT];
  assign rtc_in         = pin_i[PB*PORT_W+PB_RTC_LO +: 2];
  assign timer_clk_in   = pin_i[PA*PORT_W+PA_TCLK_A +: 3];
  assign quad_first_in  = pin_i[PA*PORT_W +: 2];
  assign quad_second_in = pin_i[PA*PORT_W+2 +: 2];
  assign i2s_in         = pin_i[PA*PORT_W +: 3];

  // Reads see the pin node, not the latch
  assign pin_rdata       = pin_i;
  assign port_data_latch = st.latch;
  assign port_dir        = st.dir;
  assign key_wake        = st.wake;
  // Either source ends sleep; interrupts stay level, key stays sticky-free
  assign wake_out        = sleeping & (st.wake | irq_wake);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  latch_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && data_we[0] |=> port_data_latch[7:0] == $past(data_wdata[7:0]))
    else $error("port latch not loaded");
  key_detect_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && st.arm == IOPWS_ARMED && key_wake_on && |((pin_i ^ st.snap) & wake_en)
    |=> key_wake)
    else $error("key change missed");
  // A frozen flag may outlive its cause while ce is low
  no_false_a: assert property (@(posedge clk) disable iff (!rst_n)
    key_wake && $past(ce) |-> $past(|((pin_i ^ st.snap) & wake_en)))
    else $error("spurious key wake");
  snap_arm_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && st.arm == IOPWS_IDLE && key_wake_on |=> st.snap == $past(pin_i))
    else $error("snapshot not taken");
  sleep_wake_a: assert property (@(posedge clk) disable iff (!rst_n)
    sleeping && key_wake |-> wake_out)
    else $error("sleep not ended");
  spi_own_a: assert property (@(posedge clk) disable iff (!rst_n)
    spi_en |-> pin_oe[PD*PORT_W+SPI_RX] == 1'b0 && pin_o[PD*PORT_W+SPI_TX] == spi_tx_o)
    else $error("spi pins not owned");
  gpio_pass_a: assert property (@(posedge clk) disable iff (!rst_n)
    !spi_en |-> pin_oe[31:24] == port_dir[31:24] && pin_o[31:24] == port_data_latch[31:24])
    else $error("gpio path wrong");
  pull_low_a: assert property (@(posedge clk) disable iff (!rst_n)
    pin_pd[0] |-> pull_low_en[0] && !pin_oe[0])
    else $error("pull low on driven pin");
  led_pin_a: assert property (@(posedge clk) disable iff (!rst_n)
    led_en[0] |-> pin_oe[8] && pin_o[8] == led_brightness_outputs[0])
    else $error("led pin not driven");

  cov_wake: cover property (@(posedge clk) disable iff (!rst_n) sleeping && key_wake);
  cov_spi: cover property (@(posedge clk) disable iff (!rst_n) spi_en && |data_we);
  cov_arm: cover property (@(posedge clk) disable iff (!rst_n)
    st.arm == IOPWS_IDLE ##1 st.arm == IOPWS_ARMED);

endmodule
`default_nettype wire

// >>> bench/iopws_keys.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Board model: keys, weak pull-low, floating pins
// ----------------------------------------
module iopws_keys (
  input  wire logic        clk,
  input  wire logic [31:0] pin_o,
  input  wire logic [31:0] pin_oe,
  input  wire logic [31:0] pin_pd,
  input  wire logic [31:0] key_drv,
  input  wire logic [31:0] key_lvl,
  output logic [31:0]      pin_i
);
  logic [31:0] float_pat = 32'h55555555;
  // Floating pins wander so a stale level never passes for a drive
  always @(posedge clk) begin
    float_pat <= ~float_pat;
  end
  // Device drive wins, then keys, then pull-low, else floating
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & key_drv & key_lvl)
               | (~pin_oe & ~key_drv & ~pin_pd & float_pat);
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb_top;
  import iopws_pkg::*;
  // ----------------------------------------
  // Stimulus, wiring
  // ----------------------------------------
  int n_mismatch = 0;
  int checks = 0;
  logic clk = 0, rst_n = 0, ce = 1, key_wake_on = 0, sleeping = 0, irq_wake = 0;
  logic [31:0] dir_wdata = 0, data_wdata = 0, pull_low_en = 0, wake_en = 0;
  logic [31:0] key_drv = 0, key_lvl = 0;
  logic [3:0] dir_we = 0, data_we = 0, led_en = 0, led_brightness_outputs = 0;
  logic ir_en = 0, ir_out = 0, i2s_out_en = 0, spi_en = 0;
  logic spi_cs_o = 0, spi_cs_oe = 0, spi_ck_o = 0, spi_ck_oe = 0, spi_tx_o = 0, spi_tx_oe = 0;
  logic [1:0] rtc_en = 0, rtc_out = 0;
  logic [2:0] cc_a_en = 0, cc_a_out = 0, cc_b_en = 0, cc_b_out = 0, i2s_out = 0;
  wire logic [31:0] pin_rdata, port_data_latch, port_dir, pin_i, pin_o, pin_oe, pin_pd;
  wire logic key_wake, wake_out, ext_int_in, spi_rx_in, spi_cs_in, spi_ck_in;
  wire logic [7:0] adc_in;
  wire logic [2:0] timer_clk_in, i2s_in;
  wire logic [1:0] quad_first_in, quad_second_in, rtc_in;
  // 40 ns period
  always #20 clk = ~clk;
  iopws_port u_iopws_port (.clk, .rst_n, .ce, .dir_wdata, .dir_we, .data_wdata, .data_we,
    .pull_low_en, .wake_en, .key_wake_on, .sleeping, .pin_rdata, .port_data_latch, .port_dir,
    .key_wake, .wake_out, .irq_wake, .pin_i, .pin_o, .pin_oe, .pin_pd, .led_en,
    .led_brightness_outputs, .ir_en, .ir_out, .rtc_en, .rtc_out, .cc_a_en, .cc_a_out,
    .cc_b_en, .cc_b_out, .i2s_out_en, .i2s_out, .spi_en, .spi_cs_o, .spi_cs_oe, .spi_ck_o,
    .spi_ck_oe, .spi_tx_o, .spi_tx_oe, .adc_in, .timer_clk_in, .quad_first_in,
    .quad_second_in, .i2s_in, .ext_int_in, .rtc_in, .spi_rx_in, .spi_cs_in, .spi_ck_in);
  iopws_keys u_iopws_keys (.clk, .pin_o, .pin_oe, .pin_pd, .key_drv, .key_lvl, .pin_i);
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Same value into data and direction lanes
  task automatic wr(input logic [3:0] dw, input logic [3:0] rw, input logic [31:0] v);
    @(posedge clk);
    data_we <= dw;
    dir_we <= rw;
    data_wdata <= v;
    dir_wdata <= v;
    @(posedge clk);
    data_we <= 4'h0;
    dir_we <= 4'h0;
    #1;
  endtask
  task automatic t_gpio;
    @(posedge clk);
    pull_low_en <= 32'hFFFFFFFF;
    wr(4'hF, 4'hF, 32'h00FFA55A);
    `CHK("dir", port_dir, 32'h00FFA55A)
    `CHK("oe", pin_oe, 32'h00FFA55A)
    `CHK("out", pin_o & pin_oe, 32'h00FFA55A)
    `CHK("pull", pin_pd, 32'hFF005AA5)
    `CHK("rnode", pin_rdata, 32'h00FFA55A)
    wr(4'h2, 4'h0, 32'hFFFFFFFF);
    `CHK("lane", {port_data_latch, port_dir}, {32'h00FFFF5A, 32'h00FFA55A})
    // Input pins of port B read low although their latch bits are high
    `CHK("rnode_b", pin_rdata[15:8], 8'hA5)
    @(posedge clk);
    ce <= 1'b0;
    wr(4'hF, 4'hF, 32'h0);
    `CHK("frozen", {port_data_latch, port_dir}, {32'h00FFFF5A, 32'h00FFA55A})
    @(posedge clk);
    ce <= 1'b1;
    $display("t_gpio done");
  endtask
  task automatic t_wake;
    @(posedge clk);
    pull_low_en <= 32'h0;
    key_drv <= 32'hFFFFFFFF;
    key_lvl <= 32'h00000204;
    wake_en <= 32'h00000202;
    sleeping <= 1'b1;
    wr(4'hF, 4'hF, 32'h0);
    // Latch the present pin levels first, arm afterwards
    wr(4'hF, 4'h0, 32'h00000204);
    @(posedge clk);
    key_wake_on <= 1'b1;
    repeat (3) @(posedge clk);
    #1 `CHK("armed", {key_wake, wake_out}, 2'b00)
    @(posedge clk);
    key_lvl <= 32'h00000200;
    repeat (3) @(posedge clk);
    #1 `CHK("masked", key_wake, 1'b0)
    @(posedge clk);
    key_lvl <= 32'h0;
    repeat (2) @(posedge clk);
    #1 `CHK("wake", {key_wake, wake_out}, 2'b11)
    @(posedge clk);
    sleeping <= 1'b0;
    @(posedge clk);
    #1 `CHK("awake", {key_wake, wake_out}, 2'b10)
    @(posedge clk);
    key_lvl <= 32'h00000204;
    irq_wake <= 1'b1;
    sleeping <= 1'b1;
    repeat (2) @(posedge clk);
    #1 `CHK("irq", {key_wake, wake_out}, 2'b01)
    @(posedge clk);
    key_wake_on <= 1'b0;
    irq_wake <= 1'b0;
    sleeping <= 1'b0;
    $display("t_wake done");
  endtask
  task automatic t_share;
    @(posedge clk);
    key_drv <= 32'h08FF0000;
    key_lvl <= 32'h083C0000;
    {led_en, led_brightness_outputs, ir_en, ir_out} <= {4'hF, 4'h5, 2'b10};
    {rtc_en, rtc_out, cc_a_en, cc_a_out} <= {2'b11, 2'b01, 3'b111, 3'b110};
    {i2s_out_en, i2s_out, spi_en} <= {1'b1, 3'b101, 1'b1};
    {spi_cs_o, spi_cs_oe, spi_ck_o, spi_ck_oe, spi_tx_o, spi_tx_oe} <= 6'b110110;
    // GPIO wants every D pin out high; on D0..D3 only the SPI drives may show
    wr(4'hF, 4'hF, 32'hFF00FFFF);
    `CHK("share", pin_o[15:0], 16'h55AF)
    `CHK("spi_oe", {pin_oe[27:24], pin_o[25:24]}, 6'b001101)
    // Port A shows 8'hAF and port B 8'h55 at the pins, so the taps are known
    `CHK("a_taps", {timer_clk_in, quad_first_in, quad_second_in, i2s_in}, 10'h17F)
    `CHK("b_taps", {ext_int_in, rtc_in}, 3'b101)
    `CHK("spi_taps", {spi_rx_in, spi_cs_in, spi_ck_in}, 3'b110)
    `CHK("adc", {adc_in, spi_rx_in}, 9'h079)
    @(posedge clk);
    rtc_en <= 2'b00;
    cc_b_en <= 3'b111;
    cc_b_out <= 3'b010;
    @(posedge clk);
    #1 `CHK("cc_b", pin_o[15:8], 8'h25)
    $display("t_share done");
  endtask
  // Mid-run reset with ce low: reset must still win
  task automatic t_reset;
    @(posedge clk);
    rst_n <= 1'b0;
    ce <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    ce <= 1'b1;
    @(posedge clk);
    #1 `CHK("rst2", {port_dir, port_data_latch, key_wake}, 65'h0)
    $display("t_reset done");
  endtask
  task automatic stop_test;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1 `CHK("reset", {port_dir, port_data_latch, pin_oe, key_wake}, 97'h0)
    t_gpio();
    t_wake();
    t_share();
    t_reset();
    stop_test();
  end
  // Hang guard, well beyond the 46 or so cycles the tests need
  initial begin
    repeat (2000) @(posedge clk);
    n_mismatch++;
    stop_test();
  end
endmodule
`default_nettype wire
